// File: rtl/etq_pkg.sv
// Shared constants, types and encodings for the transmit configuration block
`default_nettype none
package etq_pkg;
	// Register offsets in the host port space
	localparam logic [15:0] ETQ_OFF_TX_IRQ_CFG = 16'h0106;
	localparam logic [15:0] ETQ_OFF_BUF_IRQ_CFG = 16'h010a;
	localparam logic [15:0] ETQ_OFF_LINE_CTL = 16'h0112;
	localparam logic [15:0] ETQ_OFF_TEST_CTL = 16'h0118;
	localparam logic [15:0] ETQ_OFF_HOST_STAT = 16'h0138;
	localparam logic [15:0] ETQ_OFF_TX_CMD = 16'h0144;
	localparam logic [15:0] ETQ_OFF_TX_LEN = 16'h0146;
	// Reset value of every register
	localparam logic [15:0] ETQ_RST_REG = 16'h0000;
	// Line control fields
	localparam int LC_TX_EN = 7;
	localparam int LC_AUI_FORCE = 8;
	localparam int LC_AUTO_SEL = 9;
	localparam int LC_MOD_BACKOFF = 11;
	localparam int LC_DEFER_OFF = 13;
	// Test control field
	localparam int TC_LT_BYPASS = 7;
	// Buffer interrupt enables
	localparam int BC_SPACE = 8;
	localparam int BC_UNDERFLOW = 9;
	localparam int BC_COL_WRAP = 12;
	// Transmit interrupt enables
	localparam int XC_CRS_LOSS = 6;
	localparam int XC_SQE = 7;
	localparam int XC_DONE = 8;
	localparam int XC_LATE_COL = 9;
	localparam int XC_OVERLONG = 10;
	localparam int XC_COL = 11;
	localparam int XC_EXCESS = 15;
	// Transmit command fields
	localparam int CMD_START_LO = 6;
	localparam int CMD_START_HI = 7;
	localparam int CMD_FORCE = 8;
	localparam int CMD_ONE_COL = 9;
	localparam int CMD_NO_CRC = 12;
	localparam int CMD_NO_PAD = 13;
	// Status fields
	localparam int ST_BID_ERR = 7;
	localparam int ST_SPACE_NOW = 8;
	// Frame sizing and start thresholds in bytes, and the transmit attempt limit
	localparam logic [10:0] ETQ_PAD_DATA = 11'd60;
	localparam logic [10:0] ETQ_CRC_BYTES = 11'd4;
	localparam logic [10:0] ETQ_RUNT_MIN = 11'd3;
	localparam logic [10:0] ETQ_MAX_LEN = 11'd1514;
	localparam logic [10:0] ETQ_THR_A = 11'd5;
	localparam logic [10:0] ETQ_THR_B = 11'd381;
	localparam logic [10:0] ETQ_THR_C = 11'd1021;
	localparam logic [4:0] ETQ_MAX_TRIES = 5'd16;
	// Transmit request progress
	typedef enum logic [1:0] {
		BID_IDLE = 2'b00,
		BID_CMD = 2'b01,
		BID_WAIT = 2'b10,
		BID_RDY = 2'b11
	} etq_bid_t;
	// Events reported by the MAC core, one-cycle pulses
	typedef struct packed {
		logic done;
		logic late_col;
		logic overlong;
		logic collision;
		logic sqe;
		logic crs_loss;
	} etq_ev_t;
endpackage : etq_pkg
`default_nettype wire

// File: rtl/etq_fifo.sv
// Byte FIFO between the host data port and the line output stage
`timescale 1ns/100ps
`default_nettype none
module etq_fifo
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_flush,
	input wire logic [WIDTH-1:0] i_data,
	input wire logic i_valid,
	output logic o_ready,
	output logic [WIDTH-1:0] o_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [$clog2(DEPTH):0] o_count
);
	localparam int AW = $clog2(DEPTH);
	// Pointers wrap naturally only for a power of two
	if (DEPTH < 2 || (1 << AW) != DEPTH)
		$error("etq_fifo: DEPTH must be a power of two, at least 2");
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;
	// Honest flags straight from the occupancy count
	assign o_ready = (count_reg != DEPTH[AW:0]);
	assign o_valid = (count_reg != '0);
	assign o_data = mem[rd_ptr_reg];
	assign o_count = count_reg;
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;
	// Storage has no reset; only the pointers matter
	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= i_data;
	end
	// Pointers and count; flush drops everything held
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else if (i_flush)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(pop);
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : etq_fifo
`default_nettype wire

// File: rtl/etq_tx_cfg.sv
// Transmit configuration, transmit request and frame gating for the Ethernet MAC
`timescale 1ns/100ps
`default_nettype none
module etq_tx_cfg
	import etq_pkg::*;
#(
	parameter int FIFO_DEPTH = 16,
	parameter int COL_CNT_W = 10
)
(
	input wire logic I_CLK,
	input wire logic I_RST_N,
	input wire logic [15:0] I_ADDR,
	input wire logic [15:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	output logic [15:0] O_RDATA,
	input wire logic [7:0] I_TXD_DATA,
	input wire logic I_TXD_VALID,
	output logic O_TXD_READY,
	output logic [7:0] O_TX_DATA,
	output logic O_TX_VALID,
	output logic O_TX_LAST,
	input wire logic I_LINE_READY,
	input wire logic I_LINK_PULSE,
	input wire etq_ev_t I_EV,
	output logic O_PORT_AUI,
	output logic O_MOD_BACKOFF,
	output logic O_DEFER_TWO_STAGE_OFF,
	output logic O_RETRY_EN,
	output logic O_CRC_APPEND,
	output logic [10:0] O_WIRE_LEN,
	output logic O_IRQ
);
	if (FIFO_DEPTH < 2 || COL_CNT_W < 1)
		$error("etq_tx_cfg: FIFO_DEPTH or COL_CNT_W out of range");
	localparam int CW = $clog2(FIFO_DEPTH);
	// Preamble threshold, never beyond the frame itself
	function automatic logic [10:0] start_thr(input logic [15:0] cmd, input logic [10:0] len);
		logic [10:0] t;
		t = len;
		unique case (cmd[CMD_START_HI:CMD_START_LO])
			2'b00: t = ETQ_THR_A;
			2'b10: t = ETQ_THR_B;
			2'b01: t = ETQ_THR_C;
			2'b11: t = len;
		endcase
		return (t < len) ? t : len;
	endfunction : start_thr
	// Bytes on the wire after padding and CRC
	function automatic logic [10:0] wire_len(input logic [15:0] cmd, input logic [10:0] len);
		logic [10:0] n;
		n = len;
		if (!cmd[CMD_NO_PAD] && len < ETQ_PAD_DATA)
			n = ETQ_PAD_DATA;
		if (!cmd[CMD_NO_CRC])
			n = n + ETQ_CRC_BYTES;
		return n;
	endfunction : wire_len
	logic link_meta_reg; // First synchroniser stage
	logic link_sync_reg; // Link pulses seen, safe to use
	logic [15:0] line_ctl_reg;
	logic [15:0] tx_cfg_reg;
	logic [15:0] buf_cfg_reg;
	logic [15:0] test_ctl_reg;
	logic [15:0] cmd_reg; // Command for the next bid
	logic [10:0] len_reg; // Length of the pending bid
	etq_bid_t bid_reg;
	logic bid_err_reg;
	logic space_now_reg;
	logic [15:0] frame_cmd_reg; // Command of the committed frame
	logic [10:0] frame_len_reg;
	logic frame_active_reg;
	logic started_reg; // Preamble released
	logic [10:0] in_cnt_reg;
	logic [10:0] out_cnt_reg;
	logic [4:0] tries_reg;
	logic [COL_CNT_W-1:0] col_cnt_reg;
	logic [15:0] rdata_reg;
	logic ready_reg;
	logic [7:0] tx_data_reg;
	logic tx_valid_reg;
	logic tx_last_reg;
	logic port_aui_reg;
	logic mod_backoff_reg;
	logic defer_off_reg;
	logic retry_en_reg;
	logic crc_append_reg;
	logic [10:0] wire_len_reg;
	logic irq_reg;
	logic wr_cmd, wr_len, rd_stat, force_wr, commit, len_bad, permit;
	logic push, pop, slot_free, underflow, frame_end, excess, col_wrap, kill;
	logic space_ev;
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic [CW:0] fifo_count;
	// Host port decode
	assign wr_cmd = I_WR && (I_ADDR == ETQ_OFF_TX_CMD);
	assign wr_len = I_WR && (I_ADDR == ETQ_OFF_TX_LEN);
	assign rd_stat = I_RD && (I_ADDR == ETQ_OFF_HOST_STAT);
	assign force_wr = wr_cmd && I_WDATA[CMD_FORCE];
	assign commit = (bid_reg == BID_RDY) && rd_stat;
	// Zero only legal with force; tiny runts never sent
	assign len_bad = (I_WDATA > 16'(ETQ_MAX_LEN)) || (I_WDATA == 16'h0000) ||
		(cmd_reg[CMD_NO_CRC] && cmd_reg[CMD_NO_PAD] && I_WDATA < 16'(ETQ_RUNT_MIN));
	// Transmit allowed only enabled and on a usable port
	assign permit = line_ctl_reg[LC_TX_EN] && (port_aui_reg || link_sync_reg ||
		test_ctl_reg[TC_LT_BYPASS]);
	assign push = I_TXD_VALID && ready_reg;
	assign slot_free = !tx_valid_reg || I_LINE_READY;
	assign pop = fifo_valid && started_reg && permit && slot_free;
	// Line wants a byte that the host has not supplied
	assign underflow = started_reg && permit && slot_free && !fifo_valid &&
		(out_cnt_reg < frame_len_reg);
	assign frame_end = tx_valid_reg && tx_last_reg && I_LINE_READY;
	assign excess = frame_active_reg && I_EV.collision && (tries_reg == ETQ_MAX_TRIES);
	assign col_wrap = I_EV.collision && (&col_cnt_reg);
	// One-collision frames and exhausted retries are dropped
	assign kill = force_wr || underflow || excess ||
		(frame_active_reg && I_EV.collision && frame_cmd_reg[CMD_ONE_COL]);
	assign space_ev = (bid_reg == BID_WAIT) && !frame_active_reg;
	etq_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.i_clk(I_CLK),
		.i_rst_n(I_RST_N),
		.i_flush(kill),
		.i_data(I_TXD_DATA),
		.i_valid(push),
		.o_ready(),
		.o_data(fifo_data),
		.o_valid(fifo_valid),
		.i_ready(pop),
		.o_count(fifo_count)
	);
	// Link pulse pin synchroniser
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			link_meta_reg <= 1'b0;
			link_sync_reg <= 1'b0;
		end
		else
		begin
			link_meta_reg <= I_LINK_PULSE;
			link_sync_reg <= link_meta_reg;
		end
	end
	// Configuration registers; enables used live by the event gate
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			line_ctl_reg <= ETQ_RST_REG;
			tx_cfg_reg <= ETQ_RST_REG;
			buf_cfg_reg <= ETQ_RST_REG;
			test_ctl_reg <= ETQ_RST_REG;
			cmd_reg <= ETQ_RST_REG;
		end
		else if (I_WR)
		begin
			// Port bits are not guarded; the host drops enable first
			unique case (I_ADDR)
				ETQ_OFF_LINE_CTL: line_ctl_reg <= I_WDATA;
				ETQ_OFF_TX_IRQ_CFG: tx_cfg_reg <= I_WDATA;
				ETQ_OFF_BUF_IRQ_CFG: buf_cfg_reg <= I_WDATA;
				ETQ_OFF_TEST_CTL: test_ctl_reg <= I_WDATA;
				ETQ_OFF_TX_CMD: cmd_reg <= I_WDATA;
				default: ;
			endcase
		end
	end
	// Transmit request sequence: command, length, status read
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			bid_reg <= BID_IDLE;
			len_reg <= '0;
		end
		else if (wr_cmd)
			bid_reg <= BID_CMD;
		else if (wr_len)
		begin
			len_reg <= I_WDATA[10:0];
			// Length without a fresh command, or a bad one, is dropped
			if (bid_reg != BID_CMD || len_bad)
				bid_reg <= BID_IDLE;
			else if (!frame_active_reg)
				bid_reg <= BID_RDY;
			else
				bid_reg <= BID_WAIT;
		end
		else if (space_ev)
			bid_reg <= BID_RDY;
		else if (commit)
			bid_reg <= BID_IDLE;
	end
	// Status flags; a new error beats the clear-on-read
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			bid_err_reg <= 1'b0;
			space_now_reg <= 1'b0;
		end
		else
		begin
			if (wr_len && (bid_reg != BID_CMD || (len_bad && !cmd_reg[CMD_FORCE])))
				bid_err_reg <= 1'b1;
			else if (rd_stat)
				bid_err_reg <= 1'b0;
			if (wr_cmd || commit)
				space_now_reg <= 1'b0;
			else if ((wr_len && bid_reg == BID_CMD && !len_bad && !frame_active_reg) || space_ev)
				space_now_reg <= 1'b1;
		end
	end
	// Committed frame: counts, preamble release, retry bookkeeping
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			frame_active_reg <= 1'b0;
			started_reg <= 1'b0;
			frame_cmd_reg <= ETQ_RST_REG;
			frame_len_reg <= '0;
			in_cnt_reg <= '0;
			out_cnt_reg <= '0;
			tries_reg <= '0;
		end
		else if (kill || frame_end)
		begin
			frame_active_reg <= 1'b0;
			started_reg <= 1'b0;
		end
		else if (commit)
		begin
			frame_active_reg <= 1'b1;
			started_reg <= 1'b0;
			frame_cmd_reg <= cmd_reg;
			frame_len_reg <= len_reg;
			in_cnt_reg <= '0;
			out_cnt_reg <= '0;
			tries_reg <= 5'd1;
		end
		else if (frame_active_reg)
		begin
			in_cnt_reg <= in_cnt_reg + 11'(push);
			out_cnt_reg <= out_cnt_reg + 11'(pop);
			// Preamble waits for threshold and a permitted line
			if (permit && in_cnt_reg >= start_thr(frame_cmd_reg, frame_len_reg))
				started_reg <= 1'b1;
			if (I_EV.collision)
				tries_reg <= tries_reg + 5'd1;
		end
	end
	// Free-running collision counter for statistics
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			col_cnt_reg <= '0;
		else if (I_EV.collision)
			col_cnt_reg <= col_cnt_reg + COL_CNT_W'(1);
	end
	// Host data ready, registered, so it looks one push ahead
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			ready_reg <= 1'b0;
		else
			ready_reg <= frame_active_reg && !kill && !frame_end &&
				(in_cnt_reg + 11'(push) < frame_len_reg) &&
				(fifo_count + (CW+1)'(push) - (CW+1)'(pop) < FIFO_DEPTH[CW:0]);
	end
	// Line output stage; a one-entry holding register
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			tx_data_reg <= 8'h00;
			tx_valid_reg <= 1'b0;
			tx_last_reg <= 1'b0;
		end
		else if (kill)
		begin
			tx_valid_reg <= 1'b0;
			tx_last_reg <= 1'b0;
		end
		else if (pop)
		begin
			tx_data_reg <= fifo_data;
			tx_valid_reg <= 1'b1;
			tx_last_reg <= (out_cnt_reg + 11'd1 == frame_len_reg);
		end
		else if (I_LINE_READY)
		begin
			tx_valid_reg <= 1'b0;
			tx_last_reg <= 1'b0;
		end
	end
	// Line options to the MAC core
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
		begin
			port_aui_reg <= 1'b0;
			mod_backoff_reg <= 1'b0;
			defer_off_reg <= 1'b0;
			retry_en_reg <= 1'b1;
			crc_append_reg <= 1'b1;
			wire_len_reg <= '0;
		end
		else
		begin
			// Force wins over auto; auto falls back when no link pulses
			port_aui_reg <= line_ctl_reg[LC_AUI_FORCE] ||
				(line_ctl_reg[LC_AUTO_SEL] && !link_sync_reg);
			mod_backoff_reg <= line_ctl_reg[LC_MOD_BACKOFF];
			defer_off_reg <= line_ctl_reg[LC_DEFER_OFF];
			retry_en_reg <= !frame_cmd_reg[CMD_ONE_COL];
			crc_append_reg <= !frame_cmd_reg[CMD_NO_CRC];
			wire_len_reg <= wire_len(frame_cmd_reg, frame_len_reg);
		end
	end
	// Interrupt request pulse; enables applied in the same cycle
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			irq_reg <= 1'b0;
		else
			irq_reg <= (space_ev && buf_cfg_reg[BC_SPACE]) ||
				(underflow && buf_cfg_reg[BC_UNDERFLOW]) ||
				(col_wrap && buf_cfg_reg[BC_COL_WRAP]) ||
				(I_EV.crs_loss && port_aui_reg && tx_cfg_reg[XC_CRS_LOSS]) ||
				(I_EV.sqe && tx_cfg_reg[XC_SQE]) ||
				(I_EV.done && tx_cfg_reg[XC_DONE]) ||
				(I_EV.late_col && tx_cfg_reg[XC_LATE_COL]) ||
				(I_EV.overlong && tx_cfg_reg[XC_OVERLONG]) ||
				(I_EV.collision && tx_cfg_reg[XC_COL]) ||
				(excess && tx_cfg_reg[XC_EXCESS]);
	end
	// Read data, one cycle after the read strobe
	always_ff @(posedge I_CLK or negedge I_RST_N)
	begin
		if (!I_RST_N)
			rdata_reg <= 16'h0000;
		else if (I_RD)
		begin
			unique case (I_ADDR)
				ETQ_OFF_LINE_CTL: rdata_reg <= line_ctl_reg;
				ETQ_OFF_TX_IRQ_CFG: rdata_reg <= tx_cfg_reg;
				ETQ_OFF_BUF_IRQ_CFG: rdata_reg <= buf_cfg_reg;
				ETQ_OFF_TEST_CTL: rdata_reg <= test_ctl_reg;
				ETQ_OFF_TX_CMD: rdata_reg <= cmd_reg;
				ETQ_OFF_HOST_STAT: rdata_reg <= {7'h00, space_now_reg, bid_err_reg, 7'h00};
				default: rdata_reg <= 16'h0000;
			endcase
		end
	end
	assign O_RDATA = rdata_reg;
	assign O_TXD_READY = ready_reg;
	assign O_TX_DATA = tx_data_reg;
	assign O_TX_VALID = tx_valid_reg;
	assign O_TX_LAST = tx_last_reg;
	assign O_PORT_AUI = port_aui_reg;
	assign O_MOD_BACKOFF = mod_backoff_reg;
	assign O_DEFER_TWO_STAGE_OFF = defer_off_reg;
	assign O_RETRY_EN = retry_en_reg;
	assign O_CRC_APPEND = crc_append_reg;
	assign O_WIRE_LEN = wire_len_reg;
	assign O_IRQ = irq_reg;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RST_N);
	sequence bid_cmd_s; wr_cmd; endsequence
	sequence bid_len_ok_s; wr_len && !len_bad && !frame_active_reg; endsequence
	tx_gate_a: assert property ($rose(O_TX_VALID) |-> $past(line_ctl_reg[LC_TX_EN])) else $error("tx while disabled");
	port_force_a: assert property (line_ctl_reg[LC_AUI_FORCE] |=> O_PORT_AUI) else $error("force port");
	port_auto_a: assert property (!line_ctl_reg[LC_AUI_FORCE] |=> O_PORT_AUI == $past(line_ctl_reg[LC_AUTO_SEL] && !link_sync_reg)) else $error("auto port");
	backoff_pin_a: assert property (##1 O_MOD_BACKOFF == $past(line_ctl_reg[LC_MOD_BACKOFF])) else $error("backoff");
	link_test_a: assert property ($rose(started_reg) |-> $past(port_aui_reg || link_sync_reg || test_ctl_reg[TC_LT_BYPASS])) else $error("no link");
	space_irq_a: assert property (space_ev && buf_cfg_reg[BC_SPACE] |=> O_IRQ) else $error("space irq");
	done_irq_a: assert property (I_EV.done && tx_cfg_reg[XC_DONE] |=> O_IRQ) else $error("done irq");
	crs_irq_a: assert property (I_EV.crs_loss && !port_aui_reg && $past(!I_EV.crs_loss) && !(|I_EV[5:1]) && !space_ev && !underflow && !col_wrap |=> !O_IRQ) else $error("crs tp");
	flush_all_a: assert property (force_wr |=> !frame_active_reg && !O_TX_VALID ##1 fifo_count == 0) else $error("flush");
	bid_now_a: assert property (bid_cmd_s ##1 (bid_len_ok_s and !wr_cmd) |=> space_now_reg) else $error("space now");
	thr_start_a: assert property ($rose(started_reg) |-> $past(in_cnt_reg >= start_thr(frame_cmd_reg, frame_len_reg))) else $error("early start");
endmodule : etq_tx_cfg
`default_nettype wire

// File: tb/etq_line_sink.sv
// Line-side sink model that takes the transmit byte stream
`timescale 1ns/100ps
`default_nettype none
module etq_line_sink
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_slow,
	input wire logic i_valid,
	input wire logic [7:0] i_data,
	input wire logic i_last,
	output logic o_ready,
	output int o_count,
	output logic o_last_seen
);
	logic [7:0] rx_mem [0:255]; // Received bytes in arrival order
	// Ready pattern: slow mode stalls every other cycle like a busy line
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_ready <= 1'b0;
		else if (i_slow)
			o_ready <= !o_ready;
		else
			o_ready <= 1'b1;
	end
	// Byte capture, only when both sides agree at the edge
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_count <= 0;
			o_last_seen <= 1'b0;
		end
		else if (i_valid && o_ready)
		begin
			rx_mem[o_count % 256] <= i_data;
			o_count <= o_count + 1;
			o_last_seen <= i_last;
		end
	end
endmodule : etq_line_sink
`default_nettype wire

// File: tb/test_etq_tx_cfg.sv
// Self-checking bench for the transmit configuration block
`timescale 1ns/100ps
`default_nettype none
module test_etq_tx_cfg
	import etq_pkg::*;
;
	logic clk = 1'b0; // 25 MHz clock
	logic rst_n = 1'b0; // Active-low reset
	logic [15:0] addr = '0;
	logic [15:0] wdata = '0;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic [7:0] txd = '0;
	logic txv = 1'b0;
	logic link = 1'b0; // Link pulses present
	logic slow = 1'b0; // Line stalls when set
	etq_ev_t ev = '0;
	logic [15:0] rdata;
	logic txd_ready, tx_valid, tx_last, line_ready, port_aui, mod_bo, defer_off, retry_en, crc_app, irq;
	logic [7:0] tx_data;
	logic [10:0] wire_len;
	int cnt; // Bytes taken by the line model
	logic last_seen;
	int miscompares = 0;
	int compares = 0;
	int irqs = 0; // Interrupt pulses seen
	int cycles = 0;
	int c0, i0, thr, k;
	logic [15:0] st, cmd;
	localparam logic [15:0] OFFS [7] = '{ETQ_OFF_TX_CMD, ETQ_OFF_TX_LEN, ETQ_OFF_LINE_CTL, ETQ_OFF_TX_IRQ_CFG,
		ETQ_OFF_BUF_IRQ_CFG, ETQ_OFF_TEST_CTL, 16'h0000};
	localparam int ENS [6] = '{XC_CRS_LOSS, XC_SQE, XC_COL, XC_OVERLONG, XC_LATE_COL, XC_DONE};
	etq_tx_cfg i_dut (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
		.O_RDATA(rdata), .I_TXD_DATA(txd), .I_TXD_VALID(txv), .O_TXD_READY(txd_ready), .O_TX_DATA(tx_data),
		.O_TX_VALID(tx_valid), .O_TX_LAST(tx_last), .I_LINE_READY(line_ready), .I_LINK_PULSE(link), .I_EV(ev),
		.O_PORT_AUI(port_aui), .O_MOD_BACKOFF(mod_bo), .O_DEFER_TWO_STAGE_OFF(defer_off), .O_RETRY_EN(retry_en),
		.O_CRC_APPEND(crc_app), .O_WIRE_LEN(wire_len), .O_IRQ(irq));
	etq_line_sink i_line (.i_clk(clk), .i_rst_n(rst_n), .i_slow(slow), .i_valid(tx_valid), .i_data(tx_data),
		.i_last(tx_last), .o_ready(line_ready), .o_count(cnt), .o_last_seen(last_seen));
	// Clock generation
	initial
	begin
		forever #20 clk = !clk;
	end
	// Interrupt pulse counter and hang guard, far above the expected run length
	always @(posedge clk)
	begin
		cycles++;
		if (irq === 1'b1)
			irqs++;
		if (cycles == 20000)
		begin
			miscompares++;
			final_report;
		end
	end
	task automatic cyc;
		@(posedge clk);
		#1;
	endtask : cyc
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		addr = a;
		wdata = d;
		wr_s = 1'b1;
		cyc;
		wr_s = 1'b0;
		cyc;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		addr = a;
		rd_s = 1'b1;
		cyc;
		rd_s = 1'b0;
		cyc;
		d = rdata;
	endtask : rd
	// Full request: command, length, status read, with no gap between them
	task automatic bid(input logic [15:0] c, input logic [15:0] len);
		addr = ETQ_OFF_TX_CMD;
		wdata = c;
		wr_s = 1'b1;
		cyc;
		addr = ETQ_OFF_TX_LEN;
		wdata = len;
		cyc;
		wr_s = 1'b0;
		rd_s = 1'b1;
		addr = ETQ_OFF_HOST_STAT;
		cyc;
		rd_s = 1'b0;
		cyc;
		st = rdata;
		c0 = cnt;
	endtask : bid
	// Host bytes; the line must stay silent while fewer than the start count are held
	task automatic send(input int n, input int t, input int base);
		txv = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			txd = 8'(base + i);
			if (i < t)
				chk(16'(cnt - c0), 16'h0000);
			// Ready is judged once settled, then the byte goes at the next edge
			while (txd_ready !== 1'b1)
				cyc;
			cyc;
		end
		txv = 1'b0;
	endtask : send
	task automatic drain(input int n, input int base);
		for (int j = 0; j < 400 && cnt - c0 < n; j++)
			cyc;
		chk(16'(cnt - c0), 16'(n));
		for (int i = 0; i < n; i++)
			chk(16'(i_line.rx_mem[(c0 + i) % 256]), 16'(8'(base + i)));
		chk(16'(last_seen), 16'h0001);
	endtask : drain
	task automatic pulse(input int e);
		i0 = irqs;
		ev = etq_ev_t'(6'h01 << e);
		cyc;
		ev = '0;
		repeat (3) cyc;
	endtask : pulse
	task automatic final_report;
		if (miscompares == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	// Main sequence
	initial
	begin
		repeat (16) cyc;
		rst_n = 1'b1;
		cyc;
		chk({port_aui, retry_en, crc_app}, 16'h0003);
		foreach (OFFS[o])
		begin
			rd(OFFS[o], st);
			chk(st, ETQ_RST_REG);
		end
		// Force and auto select both pick AUI without link pulses; backoff and deferral follow their bits
		wr(ETQ_OFF_LINE_CTL, 16'h2b00);
		rd(ETQ_OFF_LINE_CTL, st);
		chk(st, 16'h2b00);
		chk({port_aui, mod_bo, defer_off}, 16'h0007);
		wr(16'h0000, 16'hffff);
		rd(16'h0000, st);
		chk(st, 16'h0000);
		wr(ETQ_OFF_LINE_CTL, 16'h0100);
		chk({mod_bo, defer_off}, 16'h0000);
		// Frame held back until transmit enable is set
		bid(16'h00c0, 16'h000a);
		chk(st[ST_SPACE_NOW], 1'b1);
		send(10, 10, 8'h10);
		repeat (40) cyc;
		chk(16'(cnt - c0), 16'h0000);
		wr(ETQ_OFF_LINE_CTL, 16'h0180);
		drain(10, 8'h10);
		// Every start code and every pad/CRC pairing, with the line stalling
		slow = 1'b1;
		for (k = 0; k < 4; k++)
		begin
			cmd = 16'((k << 6) | (k << 12) | ((k & 1) << 9));
			thr = (k == 0) ? 5 : 10;
			bid(cmd, 16'h000a);
			cyc;
			chk(st[ST_SPACE_NOW], 1'b1);
			chk({retry_en, crc_app}, (k & 1) ? 16'h0000 : 16'h0003);
			chk(16'(wire_len), 16'(((k & 2) ? 10 : 60) + ((k & 1) ? 0 : 4)));
			rd(ETQ_OFF_TX_CMD, st);
			chk(st, cmd);
			send(10, thr, 16 * k);
			drain(10, 16 * k);
		end
		// Length without a command, and a runt below the floor, are refused
		wr(ETQ_OFF_TX_LEN, 16'h000a);
		rd(ETQ_OFF_HOST_STAT, st);
		chk(st[ST_BID_ERR], 1'b1);
		rd(ETQ_OFF_HOST_STAT, st);
		chk(st[ST_BID_ERR], 1'b0);
		bid(16'h3000, 16'h0002);
		chk(st[ST_BID_ERR], 1'b1);
		// Discard of a partly loaded frame
		wr(ETQ_OFF_LINE_CTL, 16'h0100);
		bid(16'h00c0, 16'h000a);
		send(3, 3, 8'h40);
		bid(16'h0100, 16'h0000);
		wr(ETQ_OFF_LINE_CTL, 16'h0180);
		repeat (40) cyc;
		chk(16'(cnt - c0), 16'h0000);
		chk(16'(txd_ready), 16'h0000);
		bid(16'h00c0, 16'h0004);
		send(4, 4, 8'h48);
		drain(4, 8'h48);
		// Second request waits for the frame in flight, then gets space and an interrupt
		wr(ETQ_OFF_LINE_CTL, 16'h0100);
		wr(ETQ_OFF_BUF_IRQ_CFG, 16'h0100);
		bid(16'h00c0, 16'h0004);
		send(4, 4, 8'h70);
		bid(16'h00c0, 16'h0004);
		chk(st[ST_SPACE_NOW], 1'b0);
		i0 = irqs;
		wr(ETQ_OFF_LINE_CTL, 16'h0180);
		drain(4, 8'h70);
		repeat (3) cyc;
		chk(16'(irqs - i0), 16'h0001);
		rd(ETQ_OFF_HOST_STAT, st);
		chk(st[ST_SPACE_NOW], 1'b1);
		c0 = cnt;
		send(4, 4, 8'h74);
		drain(4, 8'h74);
		// Port change with transmit dropped first; twisted pair without link needs bypass
		wr(ETQ_OFF_LINE_CTL, 16'h0000);
		wr(ETQ_OFF_LINE_CTL, 16'h0080);
		chk(16'(port_aui), 16'h0000);
		bid(16'h00c0, 16'h0006);
		send(6, 6, 8'h50);
		repeat (40) cyc;
		chk(16'(cnt - c0), 16'h0000);
		wr(ETQ_OFF_TEST_CTL, 16'h0080);
		drain(6, 8'h50);
		wr(ETQ_OFF_LINE_CTL, 16'h0000);
		link = 1'b1;
		wr(ETQ_OFF_LINE_CTL, 16'h0200);
		repeat (4) cyc;
		chk(16'(port_aui), 16'h0000);
		link = 1'b0;
		repeat (4) cyc;
		chk(16'(port_aui), 16'h0001);
		wr(ETQ_OFF_LINE_CTL, 16'h0300);
		chk(16'(port_aui), 16'h0001);
		// Each event alone enabled, then all but it enabled
		wr(ETQ_OFF_LINE_CTL, 16'h0100);
		for (k = 0; k < 6; k++)
		begin
			wr(ETQ_OFF_TX_IRQ_CFG, 16'(1 << ENS[k]));
			pulse(k);
			chk(16'(irqs - i0), 16'h0001);
			wr(ETQ_OFF_TX_IRQ_CFG, 16'h8fc0 & ~16'(1 << ENS[k]));
			pulse(k);
			chk(16'(irqs - i0), 16'h0000);
		end
		wr(ETQ_OFF_LINE_CTL, 16'h0000);
		wr(ETQ_OFF_TX_IRQ_CFG, 16'h0040);
		pulse(0);
		chk(16'(irqs - i0), 16'h0000);
		// A full lap of collisions wraps the counter exactly once
		wr(ETQ_OFF_BUF_IRQ_CFG, 16'h1000);
		i0 = irqs;
		ev.collision = 1'b1;
		repeat (1024) cyc;
		ev = '0;
		repeat (3) cyc;
		chk(16'(irqs - i0), 16'h0001);
		// Sixteen failed attempts on one frame: interrupt and the frame is dropped
		wr(ETQ_OFF_BUF_IRQ_CFG, 16'h0000);
		wr(ETQ_OFF_TX_IRQ_CFG, 16'h8000);
		bid(16'h00c0, 16'h000a);
		i0 = irqs;
		ev.collision = 1'b1;
		repeat (15) cyc;
		chk(16'(irqs - i0), 16'h0000);
		cyc;
		ev = '0;
		repeat (3) cyc;
		chk(16'(irqs - i0), 16'h0001);
		chk(16'(txd_ready), 16'h0000);
		// Data runs out after the start: underflow interrupt
		wr(ETQ_OFF_TX_IRQ_CFG, 16'h0000);
		wr(ETQ_OFF_BUF_IRQ_CFG, 16'h0200);
		wr(ETQ_OFF_LINE_CTL, 16'h0180);
		slow = 1'b0;
		bid(16'h0000, 16'h000a);
		i0 = irqs;
		send(5, 5, 8'h60);
		repeat (40) cyc;
		chk(16'(irqs - i0), 16'h0001);
		final_report;
	end
endmodule : test_etq_tx_cfg
`default_nettype wire
